// [src/mrv_margin_verify.v]
/*
 Margin verify command interpreter of the tag controller. Takes the command
 one bit per cycle after the opcode has been recognised, checks handle, CRC,
 length and power, compares the addressed memory bits against the mask under
 margined read, and shifts out the passing reply. Also holds the capacitance
 trim from power-up and the backscatter encoding selection.
 Every refusal is silent; only a valid frame met at low power earns the
 error reply, so the reader never mistakes a brown-out for a failed verify.
 Assumes a bit-serial demodulator front end, a margined NVM read port and a
 reverse link modulator that accept the signals below; nrst is power-on.
*/
`timescale 1ns/1ps
`include "mrv_regs.vh"

module mrv_margin_verify (
  input  wire        sys_clk,        // 10 MHz clock
  input  wire        nrst,           // Synchronous reset, active low
  input  wire        cmd_start,      // Pulse: opcode recognised, fields follow
  input  wire        rx_valid,       // Pulse: one command bit on rx_bit
  input  wire        rx_bit,         // Command bit, MSB first
  input  wire        rx_end,         // Pulse: end of command frame
  input  wire        state_open,     // Tag in open state
  input  wire        state_secured,  // Tag in secured state
  input  wire [15:0] cur_handle,     // Current handle of the tag
  input  wire        power_ok,       // Enough power for margined read
  input  wire        query_trext,    // Pilot-tone bit of the round's query
  input  wire [1:0]  link_enc,       // Encoding chosen by reader (0 FM0)
  input  wire [3:0]  trim_meas,      // Trim value found by the tuner
  input  wire        trim_done,      // Pulse: tuner finished at power-up
  input  wire [95:0] tid_rom,        // Class, maker, model, header, serial
  input  wire        nvm_margin_bit, // Margined read of the addressed bit
  output reg  [1:0]  nvm_bank,       // Bank addressed for margined read
  output reg  [7:0]  nvm_addr,       // Bit address for margined read
  output reg         nvm_margin_en,  // Margined read mode active
  output reg         tx_start,       // Pulse: begin reply
  output reg         tx_pilot,       // Preamble with pilot tone
  output reg         tx_miller,      // Miller subcarrier, else FM0
  output reg         tx_error,       // Reply is insufficient-power error
  output reg         tx_valid,       // Reply bit present
  output reg         tx_bit,         // Reply bit
  output reg  [3:0]  cap_trim        // Held input capacitance trim
);

  // Parser states follow the command fields in order; WAIT holds the
  // verdict until the front end marks the end of the frame
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_BANK = 3'h1;
  localparam [2:0] ST_PTR  = 3'h2;
  localparam [2:0] ST_LEN  = 3'h3;
  localparam [2:0] ST_MASK = 3'h4;
  localparam [2:0] ST_TAIL = 3'h5;
  localparam [2:0] ST_WAIT = 3'h6;
  localparam [2:0] ST_SEND = 3'h7;

  // Parser and field registers
  reg [2:0]  state_r;
  reg [15:0] crc_r;
  reg [7:0]  cnt_r;
  reg [1:0]  bank_r;
  reg [7:0]  ptr_r;
  reg [2:0]  ebv_blk_r;
  reg        ebv_more_r;
  reg [7:0]  len_r;
  reg        ptr_bad_r;
  reg        mis_r;
  // Captured tail and the reply being shifted out
  reg [31:0] tail_r;
  reg [32:0] reply_r;
  reg [5:0]  txcnt_r;
  // Trim hold
  reg        trim_lock_r;
  reg        trim_dis_r;
  // Combinational helpers; each loop index belongs to one process only
  reg [15:0] reply_crc;
  reg [15:0] opc_crc;
  integer    i;
  integer    j;

  // CRC-16 step over one bit, shared by receive and reply paths
  // MSB first; the register is never complemented here, callers do that
  function [15:0] mrv_crc_step;
    input [15:0] crc;
    input        din;
    begin
      if (crc[15] ^ din)
        mrv_crc_step = {crc[14:0], 1'b0} ^ `MRV_CRC_POLY;
      else
        mrv_crc_step = {crc[14:0], 1'b0};
    end
  endfunction

  // Size of the programmable part of a bank; zero where nothing is writable
  // TID is ROM and user memory is absent, so both verify as out of range
  function [8:0] mrv_bank_size;
    input [1:0] bank;
    begin
      case (bank)
        `MRV_BANK_RSV: mrv_bank_size = {1'b0, `MRV_RSV_BITS};
        `MRV_BANK_EPC: mrv_bank_size = {1'b0, `MRV_EPC_BITS};
        default:       mrv_bank_size = 9'h000;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Trim is captured once; later tuner pulses are ignored until power-down
  // The lock is set even when the disable bit keeps the default, so a late
  // tuner pulse cannot retune the front end in the middle of a round
  always @(posedge sys_clk) begin
    if (!nrst) begin
      cap_trim    <= `MRV_TRIM_DEF;
      trim_lock_r <= 1'b0;
    end else if (trim_done && !trim_lock_r) begin
      trim_lock_r <= 1'b1;
      if (!trim_dis_r)
        cap_trim <= trim_meas;
    end
  end

  // Trim disable bit lives in reserved NVM; without an NVM write path it
  // powers up clear, which keeps the tuner in charge
  // Limitation: the bit cannot be set from this block
  always @(posedge sys_clk) begin
    if (!nrst)
      trim_dis_r <= 1'b0;
    else
      trim_dis_r <= trim_dis_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply CRC over header and handle, computed combinationally
  // The handle only changes between commands, so the value is steady while
  // the reply shifts out; the complement is what goes on the air
  always @* begin
    reply_crc = `MRV_CRC_INIT;
    reply_crc = mrv_crc_step(reply_crc, 1'b0);
    for (i = 15; i >= 0; i = i - 1)
      reply_crc = mrv_crc_step(reply_crc, cur_handle[i]);
    reply_crc = ~reply_crc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command parser; field order follows the command frame
  // Bits are taken only on rx_valid, so gaps from the demodulator are
  // harmless; the CRC runs over every field bit, the received CRC included
  always @(posedge sys_clk) begin
    if (!nrst) begin
      // All outputs but cap_trim idle low and the margined read is off
      state_r       <= ST_IDLE;
      crc_r         <= `MRV_CRC_INIT;
      cnt_r         <= 8'h00;
      bank_r        <= 2'h0;
      ptr_r         <= 8'h00;
      ebv_blk_r     <= 3'h0;
      ebv_more_r    <= 1'b0;
      len_r         <= 8'h00;
      ptr_bad_r     <= 1'b0;
      mis_r         <= 1'b0;
      tail_r        <= 32'h0000_0000;
      reply_r       <= 33'h0_0000_0000;
      txcnt_r       <= 6'h00;
      nvm_bank      <= 2'h0;
      nvm_addr      <= 8'h00;
      nvm_margin_en <= 1'b0;
      tx_start      <= 1'b0;
      tx_pilot      <= 1'b0;
      tx_miller     <= 1'b0;
      tx_error      <= 1'b0;
      tx_valid      <= 1'b0;
      tx_bit        <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      tx_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Opcode seeds the CRC so the residue check covers the whole frame;
          // outside open or secured the frame passes by unseen
          if (cmd_start && (state_open || state_secured)) begin
            crc_r      <= opc_crc;
            cnt_r      <= 8'h00;
            ptr_r      <= 8'h00;
            ebv_blk_r  <= 3'h0;
            ptr_bad_r  <= 1'b0;
            mis_r      <= 1'b0;
            state_r    <= ST_BANK;
          end
        end
        ST_BANK: if (rx_valid) begin
          // Two bank bits, MSB first; the decode happens at the bounds check
          crc_r  <= mrv_crc_step(crc_r, rx_bit);
          bank_r <= {bank_r[0], rx_bit};
          cnt_r  <= cnt_r + 8'h01;
          if (cnt_r == `MRV_BANK_LAST) begin
            cnt_r   <= 8'h00;
            state_r <= ST_PTR;
          end
        end
        ST_PTR: if (rx_valid) begin
          // EBV: 8-bit blocks sent MSB first; the first bit of a block is the
          // extension flag and the other seven are address bits. A pointer
          // that will not fit eight bits is marked bad, not truncated
          crc_r <= mrv_crc_step(crc_r, rx_bit);
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'h00)
            ebv_more_r <= rx_bit;
          else begin
            if (ebv_blk_r != 3'h0 && ptr_r[7])
              ptr_bad_r <= 1'b1;                                  // Beyond any bank
            ptr_r <= {ptr_r[6:0], rx_bit};
          end
          if (cnt_r == `MRV_BYTE_LAST) begin
            cnt_r     <= 8'h00;
            ebv_blk_r <= ebv_blk_r + 3'h1;
            if (ebv_blk_r == `MRV_EBV_MAX)
              ptr_bad_r <= 1'b1;
            if (!ebv_more_r)
              state_r <= ST_LEN;
          end
        end
        ST_LEN: if (rx_valid) begin
          // Length closes the address phase: the margined read starts with
          // the first mask bit and the bounds check sees the whole span
          crc_r <= mrv_crc_step(crc_r, rx_bit);
          len_r <= {len_r[6:0], rx_bit};
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == `MRV_BYTE_LAST) begin
            cnt_r         <= 8'h00;
            nvm_bank      <= bank_r;
            nvm_addr      <= ptr_r;
            nvm_margin_en <= 1'b1;
            state_r       <= ({len_r[6:0], rx_bit} == 8'h00) ? ST_TAIL : ST_MASK;
            if ({1'b0, ptr_r} + {1'b0, len_r[6:0], rx_bit} > mrv_bank_size(bank_r))
              ptr_bad_r <= 1'b1;
          end
        end
        ST_MASK: if (rx_valid) begin
          // The margined bit for the registered nvm_addr is read in the cycle
          // in which the mask bit arrives; a mismatch is sticky and the rest
          // of the mask still feeds the CRC
          crc_r <= mrv_crc_step(crc_r, rx_bit);
          if (nvm_margin_bit != rx_bit)
            mis_r <= 1'b1;
          nvm_addr <= nvm_addr + 8'h01;
          cnt_r    <= cnt_r + 8'h01;
          if (cnt_r + 8'h01 == len_r) begin
            cnt_r         <= 8'h00;
            nvm_margin_en <= 1'b0;
            state_r       <= ST_TAIL;
          end
        end
        ST_TAIL: if (rx_valid) begin
          // Handle then CRC; a frame that ends early is dropped without
          // a verdict, since its CRC can never have been checked
          crc_r  <= mrv_crc_step(crc_r, rx_bit);
          tail_r <= {tail_r[30:0], rx_bit};
          cnt_r  <= cnt_r + 8'h01;
          if (cnt_r == `MRV_TAIL_LAST)
            state_r <= ST_WAIT;
        end else if (rx_end)
          state_r <= ST_IDLE;                                     // Short frame
        ST_WAIT: begin
          // Verdict waits for the end of frame. Power is judged before the
          // compare result, since a margined read at low power proves nothing;
          // handle, CRC and length must still be good for any reply at all
          nvm_margin_en <= 1'b0;
          if (rx_end) begin
            state_r <= ST_IDLE;
            if (crc_r == `MRV_CRC_RESIDUE &&
                tail_r[31:16] == cur_handle &&
                len_r != 8'h00) begin
              if (!power_ok) begin
                tx_start  <= 1'b1;
                tx_error  <= 1'b1;
                tx_pilot  <= query_trext;
                tx_miller <= (link_enc != `MRV_ENC_FM0);
              end else if (!mis_r && !ptr_bad_r) begin
                tx_start  <= 1'b1;
                tx_error  <= 1'b0;
                tx_pilot  <= query_trext;
                tx_miller <= (link_enc != `MRV_ENC_FM0);
                reply_r   <= {1'b0, cur_handle, reply_crc};
                txcnt_r   <= `MRV_REPLY_BITS;
                state_r   <= ST_SEND;
              end
            end
          end
        end
        ST_SEND: begin
          // Modulator takes one bit per cycle after tx_start
          // The header bit leaves first; the counter ends the burst
          tx_valid <= 1'b1;
          tx_bit   <= reply_r[32];
          reply_r  <= {reply_r[31:0], 1'b0};
          txcnt_r  <= txcnt_r - 6'h01;
          if (txcnt_r == 6'h01)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CRC state after the 16 opcode bits, which the front end already consumed;
  // the opcode is fixed, so this folds to a constant and costs no flops
  always @* begin
    opc_crc = `MRV_CRC_INIT;
    for (j = 15; j >= 0; j = j - 1)
      opc_crc = mrv_crc_step(opc_crc, opc_bits(j));
  end

  function opc_bits;
    input integer k;
    reg [15:0] op;
    begin
      op       = `MRV_OPCODE;
      opc_bits = op[k];
    end
  endfunction

  // TID ROM is read-only and is never a verify target
  // Kept as a port so the ROM stays wired; the reduction only marks it read
  wire tid_unused = ^tid_rom;

endmodule

// [src/mrv_regs.vh]
/*
 Constants for the margin verify command interpreter: command framing,
 bank codes, reply layout and memory organisation.
 Assumes nothing beyond being included by its bare name.
*/
`ifndef MRV_REGS_VH
`define MRV_REGS_VH
`define MRV_OPCODE        16'hE001
`define MRV_BANK_RSV      2'h0
`define MRV_BANK_EPC      2'h1
`define MRV_BANK_TID      2'h2
`define MRV_BANK_USER     2'h3
`define MRV_EPC_BITS      8'h60
`define MRV_RSV_BITS      8'h20
`define MRV_TRIM_DIS_BIT  8'h1F
`define MRV_TID_BITS      8'h60
`define MRV_REPLY_BITS    6'h21
`define MRV_CRC_INIT      16'hFFFF
`define MRV_CRC_POLY      16'h1021
`define MRV_CRC_RESIDUE   16'h1D0F
`define MRV_EBV_MAX       3'h3
`define MRV_LAST_BIT16    5'h0F
`define MRV_BANK_LAST     8'h01
`define MRV_BYTE_LAST     8'h07
`define MRV_TAIL_LAST     8'h1F
`define MRV_ENC_FM0       2'h0
`define MRV_TRIM_W        4
`define MRV_TRIM_DEF      4'h8
`endif

// [tb/mrv_nvm_model.sv]
/*
 Margined-read memory model: reserved bits 0..31 of image, EPC bits 32..127.
 Assumes the bench loads image and that a read answers within the cycle of
 its registered address.
*/
`timescale 1ns/1ps
module mrv_nvm_model (
  input  wire         sys_clk, // Clock
  input  wire [1:0]   bank,    // Addressed bank
  input  wire [7:0]   addr,    // Bit address
  input  wire         en,      // Margined read active
  input  wire [127:0] image,   // Stored bits
  output reg          bit_out  // Margined read result
);
  // Read straight from the registered address, as the parser compares each
  // mask bit in its own cycle. Cells past the programmable areas answer as if
  // present, so only the design's own bounds check can refuse such a command
  always @* begin
    if (!en)
      bit_out = 1'b0;
    else if (bank == 2'h1)
      bit_out = image[addr[6:0] + 7'h20];
    else
      bit_out = image[addr[6:0]];
  end
endmodule

// [tb/mrv_chk.sv]
/*
 Assertions on the ports of the margin verify interpreter.
 Assumes one clock and the bench holding levels steady through a command.
*/
`timescale 1ns/1ps
module mrv_chk (
  input wire       sys_clk,       // Clock
  input wire       nrst,          // Reset, active low
  input wire       rx_end,        // End of frame
  input wire       state_open,    // Open state
  input wire       state_secured, // Secured state
  input wire       power_ok,      // Power level
  input wire       query_trext,   // Pilot-tone bit
  input wire [1:0] link_enc,      // Encoding
  input wire [3:0] trim_meas,     // Measured trim
  input wire       trim_done,     // Trim finished
  input wire       tx_start,      // Reply start
  input wire       tx_pilot,      // Pilot preamble
  input wire       tx_miller,     // Miller encoding
  input wire       tx_error,      // Error reply
  input wire       tx_valid,      // Reply bit valid
  input wire       tx_bit,        // Reply bit
  input wire [3:0] cap_trim       // Held trim
);
  reg       trimmed_r; // Trim taken since reset
  reg [5:0] run_r;     // Length of the current reply bit run
  // Counting the run avoids a 33-deep repetition in a property
  always @(posedge sys_clk) begin
    if (!nrst) begin
      trimmed_r <= 1'b0;
      run_r     <= 6'h00;
    end else begin
      trimmed_r <= trimmed_r | trim_done;
      run_r     <= tx_valid ? run_r + 6'h01 : 6'h00;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  start_pulse_a:
    assert property (tx_start |=> !tx_start) else $error("tx_start too long");
  reply_time_a:
    assert property (tx_start |-> $past(rx_end)) else $error("tx_start not after rx_end");
  header_zero_a:
    assert property (tx_start && !tx_error |=> tx_valid && !tx_bit) else $error("bad header");
  reply_len_a:
    assert property ($fell(tx_valid) |-> run_r == 6'h21) else $error("reply length wrong");
  err_nobits_a:
    assert property (tx_start && tx_error |=> !tx_valid [*2]) else $error("error reply has bits");
  err_power_a:
    assert property (tx_start |-> tx_error == !power_ok) else $error("error flag wrong");
  state_gate_a:
    assert property (tx_start |-> state_open || state_secured) else $error("reply out of state");
  pilot_sel_a:
    assert property (tx_valid |-> tx_pilot == query_trext) else $error("pilot wrong");
  enc_sel_a:
    assert property (tx_valid |-> tx_miller == (link_enc != 2'h0)) else $error("encoding wrong");
  trim_load_a:
    assert property (trim_done && !trimmed_r |=> cap_trim == $past(trim_meas)) else $error("trim");
  trim_hold_a:
    assert property (trimmed_r |=> $stable(cap_trim)) else $error("trim changed");
endmodule
bind mrv_margin_verify mrv_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .rx_end(rx_end),
  .state_open(state_open), .state_secured(state_secured), .power_ok(power_ok),
  .query_trext(query_trext), .link_enc(link_enc), .trim_meas(trim_meas),
  .trim_done(trim_done), .tx_start(tx_start), .tx_pilot(tx_pilot), .tx_miller(tx_miller),
  .tx_error(tx_error), .tx_valid(tx_valid), .tx_bit(tx_bit), .cap_trim(cap_trim));

// [tb/tb.sv]
/*
 Self-checking bench for the margin verify interpreter with random commands.
 Assumes the memory model answers a margined read in the cycle of its address.
*/
`timescale 1ns/1ps
`include "mrv_regs.vh"
module tb;
  reg         sys_clk, nrst, cmd_start, rx_valid, rx_bit, rx_end, trim_done;
  reg         state_open, state_secured, power_ok, query_trext;
  reg [1:0]   link_enc;
  reg [3:0]   trim_meas;
  reg [15:0]  cur_handle, crc;
  reg [127:0] image;
  reg [31:0]  seed;
  reg         q[$];
  wire [1:0]  nvm_bank;
  wire [7:0]  nvm_addr;
  wire [3:0]  cap_trim;
  wire        nvm_margin_en, nvm_margin_bit, tx_start, tx_pilot, tx_miller;
  wire        tx_error, tx_valid, tx_bit;
  integer     fail_count, tests_run, cycles, i;

  mrv_margin_verify dut (.sys_clk(sys_clk), .nrst(nrst), .cmd_start(cmd_start),
    .rx_valid(rx_valid), .rx_bit(rx_bit), .rx_end(rx_end), .state_open(state_open),
    .state_secured(state_secured), .cur_handle(cur_handle), .power_ok(power_ok),
    .query_trext(query_trext), .link_enc(link_enc), .trim_meas(trim_meas),
    .trim_done(trim_done), .tid_rom(96'h0), .nvm_margin_bit(nvm_margin_bit),
    .nvm_bank(nvm_bank), .nvm_addr(nvm_addr), .nvm_margin_en(nvm_margin_en),
    .tx_start(tx_start), .tx_pilot(tx_pilot), .tx_miller(tx_miller), .tx_error(tx_error),
    .tx_valid(tx_valid), .tx_bit(tx_bit), .cap_trim(cap_trim));
  mrv_nvm_model nvm (.sys_clk(sys_clk), .bank(nvm_bank), .addr(nvm_addr),
    .en(nvm_margin_en), .image(image), .bit_out(nvm_margin_bit));

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [15:0] crc_bit(input [15:0] c, input b);
    crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `MRV_CRC_POLY : 16'h0000);
  endfunction
  task check(input [7:0] got, input [7:0] want);
    begin
      tests_run = tests_run + 1;
      if (got !== want) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  // Queue the low w bits MSB first, folding them into the running CRC
  task put(input [15:0] v, input integer w);
    integer k;
    begin
      for (k = w - 1; k >= 0; k = k - 1) begin
        q.push_back(v[k]);
        crc = crc_bit(crc, v[k]);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // One random command; the model decides if a pass, an error or silence is due
  task run_cmd;
    reg [1:0]  bk;
    reg [7:0]  ptr, len;
    reg [15:0] hd, c;
    reg [32:0] r;
    reg        ok, go, pw, wr, bad;
    integer    sz, k;
    begin
      seed = lfsr(seed);
      bk = seed[1:0];
      ptr = {3'h0, seed[6:2]};
      len = seed[15:13] == 3'h0 ? 8'h00 : {2'h0, seed[12:7]};
      sz = bk == `MRV_BANK_RSV ? 32 : bk == `MRV_BANK_EPC ? 96 : 0;
      if (seed[16] && sz > ptr) len = 8'(sz - ptr); // Mask reaching the bank's last bit
      hd = seed[19:17] == 3'h0 ? cur_handle ^ 16'h0100 : cur_handle;
      bad = seed[22:20] == 3'h0;
      wr = seed[25:23] == 3'h0;
      ok = seed[31:29] != 3'h0 && hd == cur_handle && !bad && len != 8'h00 && ptr + len <= sz;
      pw = !(ok && seed[27:26] == 2'h0);
      go = ok && (!pw || !wr);
      q.delete();
      crc = `MRV_CRC_INIT;
      put(`MRV_OPCODE, 16);
      q.delete();
      put({14'h0, bk}, 2);
      put({8'h0, ptr}, 8);
      put({8'h0, len}, 8);
      for (k = 0; k < len; k = k + 1)
        put({15'h0, image[(bk == `MRV_BANK_EPC ? 32 : 0) + ptr + k] ^ (wr && k == 0)}, 1);
      put(hd, 16);
      c = ~crc ^ {15'h0, bad};
      put(c, 16);
      @(posedge sys_clk);
      state_open <= seed[31:29] != 3'h0 && seed[28];
      state_secured <= seed[31:29] != 3'h0 && !seed[28];
      power_ok <= pw;
      query_trext <= seed[24];
      link_enc <= seed[10:9];
      cmd_start <= 1'b1;
      @(posedge sys_clk);
      cmd_start <= 1'b0;
      for (k = 0; k < q.size(); k = k + 1) begin
        rx_valid <= 1'b1;
        rx_bit <= q[k];
        @(posedge sys_clk);
      end
      rx_valid <= 1'b0;
      @(posedge sys_clk);
      rx_end <= 1'b1;
      @(posedge sys_clk);
      rx_end <= 1'b0;
      crc = crc_bit(`MRV_CRC_INIT, 1'b0);
      for (k = 15; k >= 0; k = k - 1)
        crc = crc_bit(crc, cur_handle[k]);
      r = {1'b0, cur_handle, ~crc};
      @(posedge sys_clk);
      check({7'h0, tx_start}, {7'h0, go});
      if (go)
        check({tx_error, tx_pilot, tx_miller}, {!pw, query_trext, link_enc != 2'h0});
      for (k = 32; k >= -1; k = k - 1) begin
        @(posedge sys_clk);
        if (go && pw && k >= 0)
          check({tx_valid, tx_bit}, {1'b1, r[k]});
        else
          check({tx_start, tx_valid}, 2'b00);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // A command needs well under 300 cycles, so this ceiling only trips on a hang
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      fail_count = fail_count + 1;
      end_of_test;
    end
  end
  initial begin
    seed = 32'hE7C17A5F;
    {fail_count, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
    {nrst, cmd_start, rx_valid, rx_bit, rx_end, trim_done} = 6'h00;
    {state_open, state_secured, power_ok, query_trext, link_enc, trim_meas} = 10'h000;
    for (i = 0; i < 4; i = i + 1) begin
      seed = lfsr(seed);
      image[32 * i +: 32] = seed;
    end
    cur_handle = seed[15:0];
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check({cap_trim, 2'b00, tx_start, tx_valid}, 8'h80);
    trim_meas <= 4'h3;
    trim_done <= 1'b1;
    @(posedge sys_clk);
    trim_done <= 1'b0;
    trim_meas <= 4'hC;
    repeat (2) @(posedge sys_clk);
    check({4'h0, cap_trim}, 8'h03);
    trim_done <= 1'b1;
    @(posedge sys_clk);
    trim_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check({4'h0, cap_trim}, 8'h03);
    repeat (60) run_cmd;
    end_of_test;
  end
endmodule
